// ===== fss_pkg.sv
// Purpose: shared constants for the five-unit start-stop serial block
// Assumes: 200 MHz system clock
// Notes: line level 1 is marking, 0 is spacing
package fss_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    // signalling rates in tenths of a baud
    localparam int unsigned RATE_SLOW_DECIBAUD = 455;
    localparam int unsigned RATE_FAST_DECIBAUD = 750;
    // unit interval in clock cycles, rounded down
    localparam int unsigned UNIT_SLOW_CYC = (CLK_HZ * 10) / RATE_SLOW_DECIBAUD;
    localparam int unsigned UNIT_FAST_CYC = (CLK_HZ * 10) / RATE_FAST_DECIBAUD;
    localparam int unsigned CNT_W = 23;
    localparam int unsigned CODE_W = 5;
    localparam int unsigned FRAME_UNITS = 7;
    localparam logic [2:0] CODE_LAST_IDX = 3'h5;
    localparam logic [2:0] STOP_IDX = 3'h6;
    localparam logic LINE_MARK = 1'b1;
    localparam logic LINE_SPACE = 1'b0;
    localparam logic [4:0] LETTERS_SHIFT_CODE = 5'h1f;
    localparam logic [4:0] FIGURES_SHIFT_CODE = 5'h1b;
    localparam logic [4:0] BLANK_CODE = 5'h00;
    localparam logic SHIFT_RESET = 1'b0; // letters
    typedef enum logic [2:0] {
        FSS_TX_IDLE = 3'b001,
        FSS_TX_ARMED = 3'b010,
        FSS_TX_SEND = 3'b100
    } fss_tx_st_t;
    typedef enum logic [2:0] {
        FSS_RX_IDLE = 3'b001,
        FSS_RX_START = 3'b010,
        FSS_RX_DATA = 3'b100
    } fss_rx_st_t;
endpackage : fss_pkg

// ===== fss_serial.sv
// Purpose: send and receive five-unit start-stop characters on a polar line
// Assumes: line_rx is asynchronous; key and sync pulse are from clk logic
// Notes: element 1 is sent first; shift state follows received characters
// Behaviour
// - each character starts with one spacing start element followed by five code elements.
// - a marking stop element follows the fifth code element and the receiver expects it.
// - a whole frame is exactly seven unit intervals.
// - the stop element is one unit long, like every other element.
// - marking is positive line current and spacing the opposite direction.
// - the receiver resynchronizes on the leading edge of every start element; the stop element is only sampled.
// - a letters/figures shift state selects the meaning of each non-shift code.
// - the all-marking code is letters shift and selects letters for later characters.
// - the all-spacing code is the blank code, distinct from characters and shifts.
// - the unit interval is selectable for 45.5 baud or 75 baud.
// - a dot cycle is one mark and one space pulse, so baud is twice its frequency.
// - a keyed character is sent only when a synchronizing pulse arrives.
// - once a key code is captured, other keys are refused until its frame, stop element included, has been sent.
// - sending starts on the external clock pulse after the code is set up.
module fss_serial
    import fss_pkg::*;
#(
    parameter int unsigned UNIT_SLOW = UNIT_SLOW_CYC,
    parameter int unsigned UNIT_FAST = UNIT_FAST_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rate_fast,
    input wire logic key_valid,
    input wire logic [4:0] key_code,
    input wire logic sync_pulse,
    output logic key_ready,
    output logic tx_busy,
    output logic line_tx,
    output logic dot_clk,
    input wire logic line_rx,
    output logic rx_valid,
    output logic [4:0] rx_code,
    output logic rx_figures,
    output logic rx_letters_shift,
    output logic rx_figures_shift,
    output logic rx_blank,
    output logic rx_frame_err,
    output logic shift_figures
);
    typedef struct packed {
        logic [1:0] rx_sync;
        fss_tx_st_t tx_st;
        logic [CNT_W-1:0] tx_cnt;
        logic [2:0] tx_idx;
        logic [6:0] tx_shreg;
        logic [4:0] held_code;
        logic key_ready;
        logic tx_busy;
        logic line_tx;
        logic [CNT_W-1:0] dot_cnt;
        logic dot_clk;
        fss_rx_st_t rx_st;
        logic [CNT_W-1:0] rx_cnt;
        logic [2:0] rx_idx;
        logic [4:0] rx_shreg;
        logic rx_valid;
        logic [4:0] rx_code;
        logic rx_figures;
        logic rx_letters_shift_code;
        logic rx_figures_shift_code;
        logic rx_blank;
        logic rx_err;
        logic shift;
    } fss_state_t;

    fss_state_t s_q;
    fss_state_t s_d;
    logic [CNT_W-1:0] unit_cyc;
    logic [CNT_W-1:0] half_cyc;
    logic rx_line;
    logic unit_done_dot;
    logic unit_done_tx;
    logic unit_done_rx;
    logic half_done_rx;
    logic code_letters_shift_code;
    logic code_figures_shift_code;
    logic code_blank;
    logic stop_good;

    // unit length by selected rate
    always_comb begin
        unit_cyc = rate_fast ? CNT_W'(UNIT_FAST) : CNT_W'(UNIT_SLOW);
        half_cyc = unit_cyc >> 1;
    end

    // line level after the second synchroniser flop only
    always_comb begin
        rx_line = s_q.rx_sync[1];
    end

    // end-of-unit strobes for the three timers
    always_comb begin
        unit_done_dot = (s_q.dot_cnt >= unit_cyc - CNT_W'(1));
        unit_done_tx = (s_q.tx_cnt >= unit_cyc - CNT_W'(1));
        unit_done_rx = (s_q.rx_cnt >= unit_cyc - CNT_W'(1));
        half_done_rx = (s_q.rx_cnt >= half_cyc);
    end

    // decode of the assembled receive code and the stop sample
    always_comb begin
        code_letters_shift_code = (s_q.rx_shreg == LETTERS_SHIFT_CODE);
        code_figures_shift_code = (s_q.rx_shreg == FIGURES_SHIFT_CODE);
        code_blank = (s_q.rx_shreg == BLANK_CODE);
        stop_good = (rx_line == LINE_MARK);
    end

    // next-state logic for sender, dot generator and receiver
    always_comb begin
        s_d = s_q;
        s_d.rx_valid = 1'b0;
        // two-flop synchroniser on the incoming line
        s_d.rx_sync = {s_q.rx_sync[0], line_rx};

        // dot cycle: toggle each unit, full cycle = two elements
        if (unit_done_dot) begin
            s_d.dot_cnt = '0;
            s_d.dot_clk = ~s_q.dot_clk;
        end else begin
            s_d.dot_cnt = s_q.dot_cnt + CNT_W'(1);
        end

        // sender
        case (s_q.tx_st)
            FSS_TX_IDLE: begin
                // line at rest, key taken only while ready
                s_d.line_tx = LINE_MARK;
                if (key_valid && s_q.key_ready) begin
                    s_d.held_code = key_code;
                    s_d.key_ready = 1'b0;
                    s_d.tx_st = FSS_TX_ARMED;
                end
            end
            FSS_TX_ARMED: begin
                // code held, waiting for the synchronizing pulse
                s_d.line_tx = LINE_MARK;
                if (sync_pulse) begin
                    // stop, element 5 down to 1, start; shifted out from bit 0
                    s_d.tx_shreg = {LINE_MARK,
                                    s_q.held_code[0],
                                    s_q.held_code[1],
                                    s_q.held_code[2],
                                    s_q.held_code[3],
                                    s_q.held_code[4],
                                    LINE_SPACE};
                    s_d.line_tx = LINE_SPACE;
                    s_d.tx_cnt = '0;
                    s_d.tx_idx = '0;
                    s_d.tx_st = FSS_TX_SEND;
                end
            end
            FSS_TX_SEND: begin
                // one element per unit, stop element never stretched
                if (unit_done_tx) begin
                    s_d.tx_cnt = '0;
                    if (s_q.tx_idx == STOP_IDX) begin
                        s_d.line_tx = LINE_MARK;
                        s_d.key_ready = 1'b1;
                        s_d.tx_st = FSS_TX_IDLE;
                    end else begin
                        s_d.tx_idx = s_q.tx_idx + 3'h1;
                        s_d.line_tx = s_q.tx_shreg[s_q.tx_idx + 3'h1];
                    end
                end else begin
                    s_d.tx_cnt = s_q.tx_cnt + CNT_W'(1);
                end
            end
            default: begin
                s_d.tx_st = FSS_TX_IDLE;
                s_d.key_ready = 1'b1;
                s_d.line_tx = LINE_MARK;
            end
        endcase
        // busy flag registered alongside the sender state
        s_d.tx_busy = (s_d.tx_st != FSS_TX_IDLE);

        // receiver
        case (s_q.rx_st)
            FSS_RX_IDLE: begin
                // hunt for the leading edge of a start element
                if (rx_line == LINE_SPACE) begin
                    s_d.rx_cnt = '0;
                    s_d.rx_st = FSS_RX_START;
                end
            end
            FSS_RX_START: begin
                // confirm the start element at its middle
                if (half_done_rx) begin
                    s_d.rx_cnt = '0;
                    if (rx_line == LINE_SPACE) begin
                        s_d.rx_idx = '0;
                        s_d.rx_st = FSS_RX_DATA;
                    end else begin
                        s_d.rx_st = FSS_RX_IDLE; // glitch
                    end
                end else begin
                    s_d.rx_cnt = s_q.rx_cnt + CNT_W'(1);
                end
            end
            FSS_RX_DATA: begin
                // one sample per unit from the middle of the start element
                if (unit_done_rx) begin
                    s_d.rx_cnt = '0;
                    if (s_q.rx_idx == CODE_LAST_IDX) begin
                        // stop element sampled mid-unit
                        s_d.rx_st = FSS_RX_IDLE;
                        s_d.rx_valid = 1'b1;
                        s_d.rx_code = s_q.rx_shreg;
                        s_d.rx_err = !stop_good;
                        s_d.rx_letters_shift_code = code_letters_shift_code;
                        s_d.rx_figures_shift_code = code_figures_shift_code;
                        s_d.rx_blank = code_blank;
                        s_d.rx_figures = s_q.shift;
                        // shift state moves only on a good stop element
                        if (stop_good) begin
                            if (code_letters_shift_code) begin
                                s_d.shift = 1'b0;
                            end else if (code_figures_shift_code) begin
                                s_d.shift = 1'b1;
                            end
                        end
                    end else begin
                        // element 1 lands in bit 4
                        s_d.rx_shreg = {s_q.rx_shreg[3:0], rx_line};
                        s_d.rx_idx = s_q.rx_idx + 3'h1;
                    end
                end else begin
                    s_d.rx_cnt = s_q.rx_cnt + CNT_W'(1);
                end
            end
            default: begin
                s_d.rx_st = FSS_RX_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // synchroniser resets to marking so no false start follows reset
            s_q.rx_sync <= 2'h3;
            // sender at rest, line marking
            s_q.tx_st <= FSS_TX_IDLE;
            s_q.tx_cnt <= '0;
            s_q.tx_idx <= 3'h0;
            s_q.tx_shreg <= 7'h7f;
            s_q.held_code <= 5'h00;
            s_q.key_ready <= 1'b1;
            s_q.tx_busy <= 1'b0;
            s_q.line_tx <= LINE_MARK;
            // dot generator
            s_q.dot_cnt <= '0;
            s_q.dot_clk <= LINE_MARK;
            // receiver and its results
            s_q.rx_st <= FSS_RX_IDLE;
            s_q.rx_cnt <= '0;
            s_q.rx_idx <= 3'h0;
            s_q.rx_shreg <= 5'h00;
            s_q.rx_valid <= 1'b0;
            s_q.rx_code <= 5'h00;
            s_q.rx_figures <= 1'b0;
            s_q.rx_letters_shift_code <= 1'b0;
            s_q.rx_figures_shift_code <= 1'b0;
            s_q.rx_blank <= 1'b0;
            s_q.rx_err <= 1'b0;
            // letters in force after reset
            s_q.shift <= SHIFT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state
    always_comb begin
        key_ready = s_q.key_ready;
        tx_busy = s_q.tx_busy;
        line_tx = s_q.line_tx;
        dot_clk = s_q.dot_clk;
        rx_valid = s_q.rx_valid;
        rx_code = s_q.rx_code;
        rx_figures = s_q.rx_figures;
        rx_letters_shift = s_q.rx_letters_shift_code;
        rx_figures_shift = s_q.rx_figures_shift_code;
        rx_blank = s_q.rx_blank;
        rx_frame_err = s_q.rx_err;
        shift_figures = s_q.shift;
    end
endmodule : fss_serial

// ===== fss_checker.sv
// Purpose: port assertions for the start-stop serial block
// Assumes: unit counts equal those of the bound instance
// Notes: frame timer counts from the cycle after the launching sync pulse
module fss_checker
    import fss_pkg::*;
#(
    parameter int unsigned UNIT_SLOW = 16,
    parameter int unsigned UNIT_FAST = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rate_fast,
    input wire logic key_valid,
    input wire logic sync_pulse,
    input wire logic key_ready,
    input wire logic tx_busy,
    input wire logic line_tx,
    input wire logic rx_valid,
    input wire logic [4:0] rx_code,
    input wire logic rx_letters_shift,
    input wire logic rx_blank,
    input wire logic rx_frame_err,
    input wire logic shift_figures
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic armed_q;
    int unsigned t_q;
    int unsigned u;
    assign u = rate_fast ? UNIT_FAST : UNIT_SLOW;
    // armed tracker and frame timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
            t_q <= 0;
        end else begin
            armed_q <= armed_q ? !sync_pulse : (key_valid && key_ready);
            t_q <= (armed_q && sync_pulse) ? 1 : (t_q != 0 && t_q < 7 * u) ? t_q + 1 : 0;
        end
    end
    sequence s_launch;
        armed_q && sync_pulse;
    endsequence
    AST_IDLE_MARK: assert property (!tx_busy |-> line_tx) else $error("line not marking");
    AST_ARMED_HOLD: assert property (armed_q && !sync_pulse |=> line_tx) else $error("early");
    AST_START_SYNC: assert property (s_launch |=> !line_tx && tx_busy) else $error("no start");
    AST_START_EL: assert property (t_q >= 1 && t_q <= u |-> !line_tx) else $error("start");
    AST_STOP_EL: assert property (t_q > 6 * u |-> line_tx) else $error("stop not marking");
    AST_FRAME_END: assert property (t_q == 7 * u |=> key_ready && !tx_busy) else $error("end");
    AST_KEY_LOCK: assert property (t_q != 0 |-> !key_ready) else $error("key not locked");
    AST_LETTERS_SHIFT_CODE: assert property (rx_valid |-> rx_letters_shift == (rx_code == 5'h1f)) else $error("l");
    AST_BLANK: assert property (rx_valid |-> rx_blank == (rx_code == 5'h00)) else $error("blank");
    AST_SHIFT: assert property (rx_valid && rx_letters_shift && !rx_frame_err |=> !shift_figures)
        else $error("letters not selected");
endmodule : fss_checker
bind fss_serial fss_checker #(.UNIT_SLOW(UNIT_SLOW), .UNIT_FAST(UNIT_FAST)) fss_checker_inst (
    .clk, .rst_n, .rate_fast, .key_valid, .sync_pulse, .key_ready, .tx_busy, .line_tx,
    .rx_valid, .rx_code, .rx_letters_shift, .rx_blank, .rx_frame_err, .shift_figures);

// ===== fss_remote.sv
// Purpose: remote start-stop station on the polar line
// Assumes: unit given in clk cycles
// Notes: got is unknown until a frame with good start and stop arrives
module fss_remote (
    input wire logic clk,
    input wire logic line_tx,
    input var int unit,
    output logic line_rx,
    output logic [4:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_rx = 1'b1;
    // send one frame; caller picks the stop level
    task automatic send(input logic [4:0] c, input logic stop);
        logic [6:0] f;
        f = {1'b0, c, stop};
        for (int i = 6; i >= 0; i--) begin
            line_rx <= f[i];
            repeat (unit) @(negedge clk);
        end
        line_rx <= 1'b1;
    endtask : send
    // mid-unit sampling from the start edge
    always begin
        logic [4:0] c;
        logic ok;
        @(negedge line_tx);
        got = 5'bx;
        repeat (unit / 2) @(negedge clk);
        ok = !line_tx;
        for (int i = 4; i >= 0; i--) begin
            repeat (unit) @(negedge clk);
            c[i] = line_tx;
        end
        repeat (unit) @(negedge clk);
        if (ok && line_tx) got = c;
    end
endmodule : fss_remote

// ===== fss_serial_tb.sv
// Purpose: self-checking bench for the start-stop serial block
// Assumes: short unit counts; inputs change on the falling edge
// Notes: waits are bounded
module fss_serial_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, rate_fast, key_valid, sync_pulse, key_ready, tx_busy, line_tx, dot_clk;
    logic line_rx, rx_valid, rx_figures, rx_letters_shift, rx_figures_shift, rx_blank;
    logic rx_frame_err, shift_figures;
    logic [4:0] key_code, rx_code, got;
    int unit, fail_count, comparisons;
    fss_serial #(.UNIT_SLOW(24), .UNIT_FAST(16)) fss_serial_inst (.clk, .rst_n, .rate_fast,
        .key_valid, .key_code, .sync_pulse, .key_ready, .tx_busy, .line_tx, .dot_clk, .line_rx,
        .rx_valid, .rx_code, .rx_figures, .rx_letters_shift, .rx_figures_shift, .rx_blank,
        .rx_frame_err, .shift_figures);
    fss_remote fss_remote_inst (.clk, .line_tx, .unit, .line_rx, .got);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] seen);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic await(ref logic s, input logic lvl);
        int n;
        n = 0;
        while (s !== lvl && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (s !== lvl) begin
            fail_count++;
            report_and_stop();
        end
    endtask : await
    // dot clock half cycle measured in clock cycles
    task automatic sc_dot();
        logic v;
        int n;
        v = dot_clk;
        n = 0;
        while (dot_clk === v && n < 100) begin
            @(negedge clk);
            n++;
        end
        v = dot_clk;
        n = 0;
        while (dot_clk === v && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("dot half cycle", 5'(unit), 5'(n));
    endtask : sc_dot
    // key held, second key tried while armed, then the sync pulse
    task automatic sc_send(input logic [4:0] c);
        @(negedge clk);
        key_valid = 1'b1;
        key_code = c;
        @(negedge clk);
        key_code = ~c;
        repeat (3) @(negedge clk);
        chk("line and ready while armed", 5'h2, {3'h0, line_tx, key_ready});
        sync_pulse = 1'b1;
        @(negedge clk);
        sync_pulse = 1'b0;
        key_valid = 1'b0;
        await(key_ready, 1'b1);
        chk("code seen by remote", c, got);
    endtask : sc_send
    // remote sends one frame; decode and shift state judged after it
    task automatic sc_recv(input logic [4:0] c, input logic stop, input logic [3:0] fl,
        input logic shf);
        @(negedge clk);
        fork
            fss_remote_inst.send(c, stop);
            if (stop) await(rx_valid, 1'b1);
        join
        repeat (2) @(negedge clk);
        if (stop) chk("received code", c, rx_code);
        chk("flags", {1'b0, fl}, {1'b0, rx_frame_err, rx_letters_shift, rx_figures_shift, rx_blank});
        chk("shift state", {4'h0, shf}, {4'h0, shift_figures});
    endtask : sc_recv
    initial begin
        rst_n = 1'b0;
        rate_fast = 1'b0;
        key_valid = 1'b0;
        key_code = 5'h00;
        sync_pulse = 1'b0;
        unit = 24;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        chk("idle after reset", 5'h3, {3'h0, line_tx, shift_figures ^ 1'b1});
        sc_send(5'h12);
        rate_fast = 1'b1;
        unit = 16;
        sc_send(5'h1f);
        sc_dot();
        sc_recv(5'h00, 1'b1, 4'h1, 1'b0);
        sc_recv(5'h1b, 1'b1, 4'h2, 1'b1);
        sc_recv(5'h12, 1'b1, 4'h0, 1'b1);
        chk("figures in force", 5'h1, {4'h0, rx_figures});
        sc_recv(5'h1f, 1'b1, 4'h4, 1'b0);
        sc_recv(5'h12, 1'b0, 4'h8, 1'b0);
        report_and_stop();
    end
endmodule : fss_serial_tb
